// ### rtl/dhs_pkg.sv
package dhs_pkg;
  // register map, byte addresses
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_HOLD_LO = 8'h04;
  localparam logic [7:0]  OFS_HOLD_HI = 8'h08;
  localparam logic [7:0]  OFS_SLOPE   = 8'h0c;
  localparam logic [7:0]  OFS_HARD    = 8'h10;
  localparam logic [7:0]  OFS_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_PHASE   = 8'h18;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // widths and field positions
  localparam int HOLD_W     = 40;
  localparam int SLOPE_W    = 24;
  localparam int PHASE_W    = 32;
  localparam int MODE_W     = 5;
  localparam int CTRL_W     = 13;
  localparam int STS_FLAG_B = 8;
  localparam int HIST_DEPTH = 64;

  // operating mode codes reported by the loop
  localparam logic [4:0] MODE_FREE_RUN   = 5'h01;
  localparam logic [4:0] MODE_HOLDOVER   = 5'h02;
  localparam logic [4:0] MODE_LOCKED     = 5'h04;
  localparam logic [4:0] MODE_LOST_PHASE = 5'h07;

  // history select codes
  localparam logic [1:0] HIST_NOW = 2'h0;
  localparam logic [1:0] HIST_1S  = 2'h1;
  localparam logic [1:0] HIST_8S  = 2'h2;
  localparam logic [5:0] HIST_8   = 6'h08;
  localparam logic [5:0] HIST_1   = 6'h01;

  // control register, bit 0 is man_holdover
  typedef struct packed {
    logic       mode_irq_mask;
    logic [2:0] slope_limit_select;
    logic       hitless_freeze;
    logic       hitless_en;
    logic       read_avg;
    logic [1:0] avg_filter;
    logic [1:0] hist_sel;
    logic       auto_avg;
    logic       man_holdover;
  } dhs_ctrl_type;

  localparam logic [12:0] CTRL_RESET = 13'h0e12;
  localparam logic [31:0] HARD_RESET = 32'hffff_ffff;

  // timing
  localparam int SYS_CLK_HZ    = 50_000_000;
  localparam int HIST_PERIOD_S = 1;
  localparam int SEC_CYCLES_DEF = SYS_CLK_HZ * HIST_PERIOD_S;

  // slope limits in ns/s; full scale of the 24-bit field in 0.1 ns/s
  localparam longint SLOPE_RANGE_NS_X10 = 14843614;
  localparam longint LIM_000_NS = 61000;
  localparam longint LIM_001_NS = 885;
  localparam longint LIM_010_NS = 7500;
  localparam longint LIM_100_NS = 1;
  localparam longint LIM_101_NS = 5;
  localparam longint LIM_110_NS = 10;
  localparam logic [23:0] STEP_MAX = 24'hff_ffff;

  function automatic logic [23:0] slope_step(input longint ns);
    longint v;
    v = (ns * 64'd16777216 * 64'd10) / SLOPE_RANGE_NS_X10;
    return v[23:0];
  endfunction

  // averaging shift per filter code, about 8x per step in bandwidth, 16x from code 2 to code 3
  function automatic int avg_shift(input logic [1:0] code);
    case (code)
      2'h0:    return 14;
      2'h1:    return 11;
      2'h2:    return 8;
      default: return 4;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction
endpackage

// ### rtl/dhs_core.sv
`timescale 1ns/1ps
module dhs_core
  import dhs_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // loop core
  input  wire logic [MODE_W-1:0]         loop_mode,
  input  wire logic [3:0]                ref_sel,
  input  wire logic signed [HOLD_W-1:0]  integ_freq,
  input  wire logic signed [PHASE_W-1:0] phase_err,
  // loop control
  output logic signed [HOLD_W-1:0]       freq_ctrl,
  output logic signed [PHASE_W-1:0]      phase_comp,
  output logic                           track_ref,
  output logic                           mode_irq
);

  localparam int SEC_W = $clog2(SEC_CYCLES + 1);

  if (SEC_CYCLES < 2) begin : g_chk
    $error("SEC_CYCLES must be at least 2");
  end

  dhs_ctrl_type               ctrl;
  logic [31:0]                hold_stage;
  logic signed [HOLD_W-1:0]   man_hold;
  logic [SLOPE_W-1:0]         slope_prog;
  logic [31:0]                hard_lim;
  logic                       mode_flag;
  logic [MODE_W-1:0]          mode_prev;
  logic [3:0]                 ref_prev;
  logic                       prev_hold_fr;
  logic signed [HOLD_W-1:0]   avg_cur;
  logic signed [HOLD_W-1:0]   hist_mem [HIST_DEPTH];
  logic [5:0]                 hist_ptr;
  logic [SEC_W-1:0]           sec_cnt;
  logic                       sec_tick;
  logic signed [PHASE_W-1:0]  comp_target;
  logic signed [PHASE_W+23:0] ph_acc;
  logic                       wr_go;
  logic                       rd_go;
  logic [31:0]                rd_word;
  logic                       rd_err;
  logic signed [HOLD_W:0]     avg_diff;
  logic signed [HOLD_W-1:0]   hist_val;
  logic signed [HOLD_W-1:0]   acquired;
  logic signed [HOLD_W-1:0]   hold_val;
  logic signed [HOLD_W-1:0]   lim_pos;
  logic signed [HOLD_W-1:0]   next_freq;
  logic                       clamp_hit;
  logic                       in_hold_fr;
  logic                       hs_take;
  logic [SLOPE_W-1:0]         step;
  logic signed [PHASE_W+23:0] step_w;
  logic [31:0]                next_ctrl;

  // bus handshakes
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign next_ctrl     = strb_merge({19'h0, ctrl}, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (s_axi_awaddr)
        OFS_CTRL, OFS_HOLD_LO, OFS_HOLD_HI, OFS_SLOPE, OFS_HARD,
        OFS_STATUS: s_axi_bresp <= RESP_OKAY;
        default:    s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= dhs_ctrl_type'(CTRL_RESET);
      hold_stage <= 32'h0;
      man_hold   <= '0;
      slope_prog <= '0;
      hard_lim   <= HARD_RESET;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        OFS_CTRL:    ctrl <= dhs_ctrl_type'(next_ctrl[CTRL_W-1:0]);
        OFS_HOLD_LO: hold_stage <= strb_merge(hold_stage, s_axi_wdata,
                                              s_axi_wstrb);
        OFS_HOLD_HI: begin
          if (s_axi_wstrb[0]) begin
            man_hold <= {s_axi_wdata[7:0], hold_stage};
          end
        end
        OFS_SLOPE: begin
          if (&s_axi_wstrb[2:0]) begin
            slope_prog <= s_axi_wdata[SLOPE_W-1:0];
          end
        end
        OFS_HARD:    hard_lim <= strb_merge(hard_lim, s_axi_wdata,
                                            s_axi_wstrb);
        default:     ;
      endcase
    end
  end

  // mode status and change flag, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_prev <= MODE_FREE_RUN;
      mode_flag <= 1'b0;
    end else begin
      mode_prev <= loop_mode;
      if (loop_mode != mode_prev) begin
        mode_flag <= 1'b1;
      end else if (wr_go && s_axi_awaddr == OFS_STATUS &&
                   s_axi_wstrb[1] && s_axi_wdata[STS_FLAG_B]) begin
        mode_flag <= 1'b0;
      end
    end
  end

  assign mode_irq = mode_flag & ctrl.mode_irq_mask;

  // read path
  always_comb begin
    rd_word = 32'h0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      OFS_CTRL:    rd_word = {19'h0, ctrl};
      OFS_HOLD_LO: rd_word = ctrl.read_avg ? acquired[31:0]
                                           : man_hold[31:0];
      OFS_HOLD_HI: rd_word = {24'h0, ctrl.read_avg ? acquired[39:32]
                                                   : man_hold[39:32]};
      OFS_SLOPE:   rd_word = {8'h0, slope_prog};
      OFS_HARD:    rd_word = hard_lim;
      OFS_STATUS:  rd_word = {23'h0, mode_flag, 3'h0, loop_mode};
      OFS_PHASE:   rd_word = phase_comp;
      default:     rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // holdover averaging, only while tracking a locked reference
  assign avg_diff = {integ_freq[HOLD_W-1], integ_freq}
                  - {avg_cur[HOLD_W-1], avg_cur};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avg_cur <= '0;
    end else if (loop_mode == MODE_LOCKED) begin
      avg_cur <= avg_cur + HOLD_W'(avg_diff >>> avg_shift(ctrl.avg_filter));
    end
  end

  // one-second history of the average
  assign sec_tick = (sec_cnt == SEC_W'(SEC_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_cnt  <= '0;
      hist_ptr <= 6'h0;
    end else if (sec_tick) begin
      sec_cnt  <= '0;
      hist_ptr <= hist_ptr + 6'h1;
    end else begin
      sec_cnt  <= sec_cnt + SEC_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sec_tick) hist_mem[hist_ptr] <= avg_cur;
  end

  always_comb begin
    case (ctrl.hist_sel)
      HIST_NOW: hist_val = avg_cur;
      HIST_1S:  hist_val = hist_mem[hist_ptr - HIST_1];
      HIST_8S:  hist_val = hist_mem[hist_ptr - HIST_8];
      default:  hist_val = hist_mem[hist_ptr];
    endcase
  end

  assign acquired = ctrl.auto_avg ? hist_val : avg_cur;
  assign hold_val = ctrl.man_holdover ? man_hold : acquired;

  // output frequency with hard clamp
  assign lim_pos = $signed({8'h0, hard_lim});

  always_comb begin
    case (loop_mode)
      MODE_HOLDOVER: next_freq = hold_val;
      MODE_FREE_RUN: next_freq = '0;
      default:       next_freq = integ_freq;
    endcase
    clamp_hit = (next_freq > lim_pos) || (next_freq < -lim_pos);
    if (next_freq > lim_pos) begin
      next_freq = lim_pos;
    end else if (next_freq < -lim_pos) begin
      next_freq = -lim_pos;
    end
  end

  assign in_hold_fr = (loop_mode == MODE_HOLDOVER) ||
                      (loop_mode == MODE_FREE_RUN);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_ctrl <= '0;
      track_ref <= 1'b0;
    end else begin
      freq_ctrl <= next_freq;
      track_ref <= ~in_hold_fr;
    end
  end

  // hitless switching
  assign hs_take = ctrl.hitless_en & ~ctrl.hitless_freeze & ~in_hold_fr &
                   ((ref_sel != ref_prev) | prev_hold_fr);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_prev     <= 4'h0;
      prev_hold_fr <= 1'b1;
      comp_target  <= '0;
    end else begin
      ref_prev     <= ref_sel;
      prev_hold_fr <= in_hold_fr;
      if (hs_take) begin
        comp_target <= phase_err;
      end
    end
  end

  // phase slope limiter
  always_comb begin
    case (ctrl.slope_limit_select)
      3'h0:    step = slope_step(LIM_000_NS);
      3'h1:    step = slope_step(LIM_001_NS);
      3'h2:    step = slope_step(LIM_010_NS);
      3'h3:    step = STEP_MAX;
      3'h4:    step = slope_step(LIM_100_NS);
      3'h5:    step = slope_step(LIM_101_NS);
      3'h6:    step = slope_step(LIM_110_NS);
      default: step = slope_prog;
    endcase
  end

  assign step_w = $signed({32'h0, step});

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_acc <= '0;
    end else if (ctrl.hitless_en) begin
      ph_acc <= {comp_target, 24'h0};
    end else if (ph_acc > step_w) begin
      ph_acc <= ph_acc - step_w;
    end else if (ph_acc < -step_w) begin
      ph_acc <= ph_acc + step_w;
    end else begin
      ph_acc <= '0;
    end
  end

  assign phase_comp = ph_acc[PHASE_W+23:24];

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence hold_lo_rd_s;
    rd_go && s_axi_araddr == OFS_HOLD_LO && !ctrl.read_avg;
  endsequence

  sequence slope_part_wr_s;
    wr_go && s_axi_awaddr == OFS_SLOPE && !(&s_axi_wstrb[2:0]);
  endsequence

  hold_manual_a: assert property (
    loop_mode == MODE_HOLDOVER && ctrl.man_holdover && !clamp_hit
    |=> freq_ctrl == $past(man_hold))
    else $error("manual holdover offset not applied");
  hold_now_a: assert property (
    loop_mode == MODE_HOLDOVER && !ctrl.man_holdover && ctrl.auto_avg &&
    ctrl.hist_sel == HIST_NOW && !clamp_hit
    |=> freq_ctrl == $past(avg_cur))
    else $error("holdover not using current average");
  lost_track_a: assert property (
    loop_mode == MODE_LOST_PHASE && !clamp_hit
    |=> freq_ctrl == $past(integ_freq) && track_ref)
    else $error("lost-phase not tracking reference");
  clamp_a: assert property (
    freq_ctrl <= $past(lim_pos) && freq_ctrl >= -$past(lim_pos))
    else $error("frequency outside hard limit");
  read_man_a: assert property (
    hold_lo_rd_s |=> s_axi_rvalid && s_axi_rdata == $past(man_hold[31:0]))
    else $error("offset readback not the written value");
  hs_capture_a: assert property (
    hs_take ##1 ctrl.hitless_en |=> phase_comp == $past(phase_err, 2))
    else $error("hitless offset not captured");
  freeze_hold_a: assert property (
    ctrl.hitless_freeze && ctrl.hitless_en && $stable(ctrl) [*2]
    |=> $stable(phase_comp))
    else $error("phase offset moved while frozen");
  slope_rate_a: assert property (
    !ctrl.hitless_en && $stable(ctrl)
    |=> (ph_acc - $past(ph_acc) <= $past(step_w)) &&
        ($past(ph_acc) - ph_acc <= $past(step_w)))
    else $error("phase slope exceeded");
  mode_flag_a: assert property (
    $changed(loop_mode) |=> mode_flag)
    else $error("mode change flag not set");
  slope_commit_a: assert property (
    slope_part_wr_s |=> $stable(slope_prog))
    else $error("partial slope limit write applied");

endmodule

// ### bench/dhs_core_tb.sv
`timescale 1ns/1ps
module dhs_core_tb;
  import dhs_pkg::*;
  localparam int               SEC = 16;
  localparam logic signed [39:0] K = 40'sh00_0123_4000;
  logic                      core_clk;
  logic                      reset_n;
  logic [ADDR_W-1:0]         s_axi_awaddr;
  logic                      s_axi_awvalid;
  logic                      s_axi_awready;
  logic [31:0]               s_axi_wdata;
  logic [3:0]                s_axi_wstrb;
  logic                      s_axi_wvalid;
  logic                      s_axi_wready;
  logic [1:0]                s_axi_bresp;
  logic                      s_axi_bvalid;
  logic                      s_axi_bready;
  logic [ADDR_W-1:0]         s_axi_araddr;
  logic                      s_axi_arvalid;
  logic                      s_axi_arready;
  logic [31:0]               s_axi_rdata;
  logic [1:0]                s_axi_rresp;
  logic                      s_axi_rvalid;
  logic                      s_axi_rready;
  logic [MODE_W-1:0]         loop_mode;
  logic [3:0]                ref_sel;
  logic signed [HOLD_W-1:0]  integ_freq;
  logic signed [PHASE_W-1:0] phase_err;
  logic signed [HOLD_W-1:0]  freq_ctrl;
  logic signed [PHASE_W-1:0] phase_comp;
  logic                      track_ref;
  logic                      mode_irq;
  int                        n_mismatch;
  int                        checks;
  logic [31:0]               ctrl;
  logic [31:0]               rd;
  logic [31:0]               hi;
  logic [1:0]                rsp;

  dhs_core #(.SEC_CYCLES(SEC)) dhs_core_i (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .loop_mode     (loop_mode),
    .ref_sel       (ref_sel),
    .integ_freq    (integ_freq),
    .phase_err     (phase_err),
    .freq_ctrl     (freq_ctrl),
    .phase_comp    (phase_comp),
    .track_ref     (track_ref),
    .mode_irq      (mode_irq)
  );

  always #10 core_clk = ~core_clk;

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic near(input logic signed [39:0] a);
    logic signed [39:0] d;
    d = a - K;
    return d < 64 && d > -64;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // wait at falling edges for a level that the next rising edge will see
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      conclude();
    end
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    wait_hi(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    wait_hi(s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    ctrl = v;
    wr(OFS_CTRL, ctrl, 4'hf);
  endtask

  // capture a phase offset by a reference switch, then let it slew back
  task automatic slew(input logic [2:0] code);
    set_ctrl(ctrl | 32'h80);
    phase_err <= 32'sd30;
    ref_sel   <= ref_sel + 4'h1;
    tick(4);
    check(40'(phase_comp), 40'd30);
    set_ctrl((ctrl & ~32'h0e80) | {20'h0, code, 9'h0});
    tick(8);
    check(40'(phase_comp > 10 && phase_comp < 30), 40'd1);
    tick(60);
    check(40'(phase_comp), 40'd0);
  endtask

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    loop_mode = MODE_LOCKED;
    ref_sel = 4'h1;
    integ_freq = K;
    phase_err = 32'sd40;
    n_mismatch = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdr(OFS_CTRL);
    check(40'(rd), 40'(CTRL_RESET));
    rdr(OFS_SLOPE);
    check(40'(rd), 40'h0);
    rdr(OFS_HARD);
    check(40'(rd), 40'(HARD_RESET));
    rdr(OFS_STATUS);
    check(40'(rd), 40'h104);
    check(40'(mode_irq), 40'h0);
    set_ctrl(32'h1e32);
    tick(1);
    check(40'(mode_irq), 40'h1);
    wr(OFS_STATUS, 32'h100, 4'h2);
    rdr(OFS_STATUS);
    check(40'(rd), 40'h004);
    check(40'(mode_irq), 40'h0);
    check(40'(track_ref), 40'h1);
    loop_mode <= MODE_LOST_PHASE;
    tick(3);
    check(40'(track_ref), 40'h1);
    loop_mode <= MODE_HOLDOVER;
    tick(3);
    check(40'(track_ref), 40'h0);
    loop_mode <= MODE_LOCKED;
    set_ctrl(ctrl | 32'h80);
    tick(4);
    check(40'(phase_comp), 40'h0);
    ref_sel <= 4'h2;
    tick(4);
    check(40'(phase_comp), 40'd40);
    set_ctrl(ctrl | 32'h100);
    phase_err <= 32'sd77;
    ref_sel   <= 4'h3;
    tick(4);
    loop_mode <= MODE_HOLDOVER;
    tick(3);
    loop_mode <= MODE_LOCKED;
    tick(4);
    check(40'(phase_comp), 40'd40);
    set_ctrl(ctrl & ~32'h100);
    loop_mode <= MODE_HOLDOVER;
    tick(3);
    phase_err <= 32'sd55;
    loop_mode <= MODE_LOCKED;
    tick(4);
    check(40'(phase_comp), 40'd55);
    rdr(OFS_PHASE);
    check(40'(rd), 40'd55);
    wr(OFS_PHASE, 32'h0, 4'hf);
    check(40'(rsp), 40'(RESP_SLVERR));
    set_ctrl(ctrl & ~32'h80);
    tick(20);
    check(40'(phase_comp), 40'd55);
    wr(OFS_SLOPE, 32'hff_ffff, 4'h1);
    tick(20);
    check(40'(phase_comp), 40'd55);
    wr(OFS_SLOPE, 32'hff_ffff, 4'h7);
    tick(80);
    check(40'(phase_comp), 40'd0);
    slew(3'h7);
    slew(3'h3);
    // preset 000 moves only a fraction of a unit per cycle
    set_ctrl(ctrl | 32'h80);
    phase_err <= 32'sd30;
    ref_sel   <= ref_sel + 4'h1;
    tick(4);
    set_ctrl(ctrl & ~32'h0e80);
    tick(40);
    check(40'(phase_comp >= 25 && phase_comp < 30), 40'd1);
    tick(1200);
    for (int h = 0; h < 4; h++) begin
      set_ctrl((ctrl & ~32'h4c) | 32'h40 | 32'(h << 2));
      rdr(OFS_HOLD_HI);
      hi = rd;
      rdr(OFS_HOLD_LO);
      check(40'(near({hi[7:0], rd})), 40'd1);
    end
    loop_mode <= MODE_HOLDOVER;
    tick(3);
    check(40'(near(freq_ctrl)), 40'd1);
    set_ctrl((ctrl & ~32'h40) | 32'h0d);
    tick(2);
    check(freq_ctrl, 40'h0);
    wr(OFS_HOLD_LO, 32'h1234_5678, 4'hf);
    tick(2);
    check(freq_ctrl, 40'h0);
    wr(OFS_HOLD_HI, 32'hff, 4'h1);
    tick(2);
    check(freq_ctrl, 40'hff_1234_5678);
    rdr(OFS_HOLD_LO);
    check(40'(rd), 40'h1234_5678);
    rdr(OFS_HOLD_HI);
    check(40'(rd[7:0]), 40'hff);
    wr(OFS_HARD, 32'h1000, 4'hf);
    tick(2);
    check(freq_ctrl, 40'hff_ffff_f000);
    wr(OFS_HOLD_HI, 32'h0, 4'h1);
    tick(2);
    check(freq_ctrl, 40'h00_0000_1000);
    rdr(8'h1c);
    check(40'(rsp), 40'(RESP_SLVERR));
    check(40'(rd), 40'h0);
    wr(8'h20, 32'h0, 4'hf);
    check(40'(rsp), 40'(RESP_SLVERR));
    conclude();
  end
endmodule
